// >>> core/perf_event_consts.svh
// Constants for the performance event select and count block.
// Assumes inclusion by bare name from files under core/.
`ifndef PERF_EVENT_CONSTS_SVH
`define PERF_EVENT_CONSTS_SVH

`define EV_W 6
`define CNT_W 40
`define INC_W 4
`define REG_W 3
`define LINE_W 27
`define FP_CNT_W 3
`define BP_W 4
`define FILL_BEATS 2'h3

`define EV_INTERLOCK 6'h1F
`define EV_RSVD_A 6'h20
`define EV_RSVD_B 6'h21
`define EV_FLOAT 6'h22
`define EV_BP0 6'h23
`define EV_BP1 6'h24
`define EV_BP2 6'h25
`define EV_BP3 6'h26
`define EV_HW_IRQ 6'h27
`define EV_DATA_ACC 6'h28
`define EV_DATA_MISS 6'h29
`define EV_BUS_OWN 6'h2A
`define EV_PACKED 6'h2B

`define PIN_W 5
`define PIN_REQ 0
`define PIN_PEER_SNOOP_HIT_MODIFIED 1
`define PIN_SNOOP_SNOOP_HIT_MODIFIED 2
`define PIN_GRANT 3
`define PIN_BURST_READY 4
`define PIN_RESET 5'h00

`endif

// >>> core/perf_types_pkg.sv
// Types shared by the performance event select and count block.
// Assumes perf_event_consts.svh is on the include path.
`include "perf_event_consts.svh"

package perf_types_pkg;
    typedef logic [`EV_W-1:0] evsel_t;
    typedef logic [`CNT_W-1:0] count_t;
    typedef logic [`INC_W-1:0] inc_t;
    typedef logic [`LINE_W-1:0] line_t;

    typedef enum logic [0:0] {
        FILL_IDLE = 1'b0,
        FILL_BUSY = 1'b1
    } fill_state_t;

    typedef enum logic [0:0] {
        OWN_IDLE = 1'b0,
        OWN_WAIT = 1'b1
    } own_state_t;
endpackage : perf_types_pkg

// >>> core/line_fill_filter.sv
// Data-cache miss filter: drops repeat misses to a line being filled.
// Assumes qualified miss strobes and a synchronised burst_ready.
`timescale 1ns/10ps
`default_nettype none
`include "perf_event_consts.svh"

module line_fill_filter (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] miss_valid,
    input wire logic [1:0] miss_fill,
    input wire perf_types_pkg::line_t line_0,
    input wire perf_types_pkg::line_t line_1,
    input wire logic burst_ready,
    output logic [1:0] miss_inc
);
    import perf_types_pkg::*;

    fill_state_t state, next_state;
    line_t fill_line, next_fill_line;
    logic [1:0] beats, next_beats;
    logic hit_0, hit_1;

    always_comb begin
        hit_0 = (state == FILL_BUSY) && (line_0 == fill_line);
        hit_1 = (state == FILL_BUSY) && (line_1 == fill_line);
        // Same line on both ports in one clock is one miss
        miss_inc[0] = miss_valid[0] && !hit_0;
        miss_inc[1] = miss_valid[1] && !hit_1 &&
            !(miss_inc[0] && line_1 == line_0);
        next_state = state;
        next_fill_line = fill_line;
        next_beats = beats;
        unique case (state)
            FILL_IDLE: begin
                if (miss_inc[0] && miss_fill[0]) begin
                    next_state = FILL_BUSY;
                    next_fill_line = line_0;
                    next_beats = 2'h0;
                end else if (miss_inc[1] && miss_fill[1]) begin
                    next_state = FILL_BUSY;
                    next_fill_line = line_1;
                    next_beats = 2'h0;
                end
            end
            FILL_BUSY: begin
                // Only one fill tracked; a second line just counts
                if (burst_ready) begin
                    next_beats = beats + 2'h1;
                    if (beats == `FILL_BEATS) begin
                        next_state = FILL_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= FILL_IDLE;
            fill_line <= '0;
            beats <= 2'h0;
        end else begin
            state <= next_state;
            fill_line <= next_fill_line;
            beats <= next_beats;
        end
    end
endmodule : line_fill_filter

`default_nettype wire

// >>> core/perf_event_select_count.sv
// Event selection and increment for two performance counters.
// Assumes event strobes from same-clock logic; bus pins are async.
`timescale 1ns/10ps
`default_nettype none
`include "perf_event_consts.svh"

module perf_event_select_count (
    input wire logic mclk,
    input wire logic rst_b,
    input wire perf_types_pkg::evsel_t evsel_0,
    input wire perf_types_pkg::evsel_t evsel_1,
    input wire logic ex_wr_first,
    input wire logic [`REG_W-1:0] ex_dest_first,
    input wire logic ex_wr_second,
    input wire logic [`REG_W-1:0] ex_dest_second,
    input wire logic ag_base_used_first,
    input wire logic [`REG_W-1:0] ag_base_first,
    input wire logic ag_index_used_first,
    input wire logic [`REG_W-1:0] ag_index_first,
    input wire logic ag_base_used_second,
    input wire logic [`REG_W-1:0] ag_base_second,
    input wire logic ag_index_used_second,
    input wire logic [`REG_W-1:0] ag_index_second,
    input wire logic float_op_event,
    input wire logic [`FP_CNT_W-1:0] float_op_count,
    input wire logic float_exc_zero_div,
    input wire logic float_exc_neg_sqrt,
    input wire logic float_exc_special,
    input wire logic float_exc_stack,
    input wire logic int_mul_event,
    input wire logic fpu_use_event,
    input wire logic [`BP_W-1:0] bp_code_first,
    input wire logic [`BP_W-1:0] bp_code_second,
    input wire logic [`BP_W-1:0] bp_data,
    input wire logic bp_enabled,
    input wire logic maskable_irq_taken,
    input wire logic nmi_taken,
    input wire logic [1:0] acc_valid,
    input wire logic [1:0] acc_tlb,
    input wire logic [1:0] acc_io,
    input wire logic [1:0] acc_miss,
    input wire logic [1:0] acc_fill,
    input wire perf_types_pkg::line_t acc_line_0,
    input wire perf_types_pkg::line_t acc_line_1,
    input wire logic burst_ready_b,
    input wire logic private_bus_request,
    input wire logic peer_hit_modified_b,
    input wire logic snoop_hit_modified_b,
    input wire logic private_bus_grant,
    input wire logic packed_int_first,
    input wire logic packed_int_second,
    output logic [`BP_W-1:0] breakpoint_status_pins,
    output perf_types_pkg::count_t count_0,
    output perf_types_pkg::count_t count_1
);
    import perf_types_pkg::*;

    // Address-stage operand depends on a write in execute
    function automatic logic reg_hit(
        input logic used,
        input logic [`REG_W-1:0] src
    );
        reg_hit = used && ((ex_wr_first && ex_dest_first == src) ||
            (ex_wr_second && ex_dest_second == src));
    endfunction : reg_hit

    function automatic inc_t bit_sum(input logic a, input logic b);
        bit_sum = inc_t'(a) + inc_t'(b);
    endfunction : bit_sum

    // Pin synchroniser; stage 1 feeds stage 2 only
    logic [`PIN_W-1:0] pin_raw, pin_s1, pin_s2, pin_s3;
    logic [`PIN_W-1:0] next_s1, next_s2, next_s3;

    always_comb begin
        pin_raw[`PIN_REQ] = private_bus_request;
        pin_raw[`PIN_PEER_SNOOP_HIT_MODIFIED] = !peer_hit_modified_b;
        pin_raw[`PIN_SNOOP_SNOOP_HIT_MODIFIED] = !snoop_hit_modified_b;
        pin_raw[`PIN_GRANT] = private_bus_grant;
        pin_raw[`PIN_BURST_READY] = !burst_ready_b;
        next_s1 = pin_raw;
        next_s2 = pin_s1;
        next_s3 = pin_s2;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            // Synced pins are active high; reset to idle low, no false edge
            pin_s1 <= `PIN_RESET;
            pin_s2 <= `PIN_RESET;
            pin_s3 <= `PIN_RESET;
        end else begin
            pin_s1 <= next_s1;
            pin_s2 <= next_s2;
            pin_s3 <= next_s3;
        end
    end

    logic req, grant, own_ask, req_rise;

    always_comb begin
        req = pin_s2[`PIN_REQ];
        grant = pin_s2[`PIN_GRANT];
        own_ask = req || pin_s2[`PIN_PEER_SNOOP_HIT_MODIFIED] ||
            pin_s2[`PIN_SNOOP_SNOOP_HIT_MODIFIED];
        req_rise = req && !pin_s3[`PIN_REQ];
    end

    // Ownership latency tracker
    own_state_t own_state, next_own_state;
    logic own_clock;

    always_comb begin
        next_own_state = own_state;
        own_clock = 1'b0;
        unique case (own_state)
            OWN_IDLE: begin
                if (own_ask && !grant) begin
                    next_own_state = OWN_WAIT;
                    own_clock = 1'b1;
                end
            end
            OWN_WAIT: begin
                if (grant) begin
                    next_own_state = OWN_IDLE;
                end else begin
                    own_clock = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            own_state <= OWN_IDLE;
        end else begin
            own_state <= next_own_state;
        end
    end

    // Breakpoint match, registered so pins and count agree
    logic [`BP_W-1:0] next_bp;

    always_comb begin
        next_bp = bp_code_first | bp_data |
            (bp_enabled ? bp_code_second : '0);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            breakpoint_status_pins <= '0;
        end else begin
            breakpoint_status_pins <= next_bp;
        end
    end

    // Data access qualification
    logic [1:0] acc_ok, miss_ok, miss_inc;

    always_comb begin
        acc_ok = acc_valid & ~acc_tlb & ~acc_io;
        miss_ok = acc_ok & acc_miss;
    end

    line_fill_filter u_fill (
        .mclk(mclk),
        .rst_b(rst_b),
        .miss_valid(miss_ok),
        .miss_fill(acc_fill),
        .line_0(acc_line_0),
        .line_1(acc_line_1),
        .burst_ready(pin_s2[`PIN_BURST_READY]),
        .miss_inc(miss_inc)
    );

    // Per-event increments
    logic stall_first, stall_second, float_excluded;
    inc_t inc_stall, inc_float, inc_irq, inc_acc, inc_miss;

    always_comb begin
        stall_first = reg_hit(ag_base_used_first, ag_base_first) ||
            reg_hit(ag_index_used_first, ag_index_first);
        stall_second = reg_hit(ag_base_used_second, ag_base_second) ||
            reg_hit(ag_index_used_second, ag_index_second);
        inc_stall = bit_sum(stall_first, stall_second);
        float_excluded = float_exc_zero_div || float_exc_neg_sqrt ||
            float_exc_special || float_exc_stack;
        inc_float = bit_sum(int_mul_event, fpu_use_event);
        if (float_op_event && !float_excluded) begin
            // Op count covers transcendental inner steps
            inc_float = inc_float + inc_t'(float_op_count);
        end
        inc_irq = bit_sum(maskable_irq_taken, nmi_taken);
        inc_acc = bit_sum(acc_ok[0], acc_ok[1]);
        inc_miss = bit_sum(miss_inc[0], miss_inc[1]);
    end

    // Event decode, one per counter
    function automatic inc_t select_inc(
        input evsel_t code,
        input logic second
    );
        select_inc = '0;
        unique case (code)
            `EV_INTERLOCK: select_inc = inc_stall;
            `EV_RSVD_A, `EV_RSVD_B: select_inc = '0;
            `EV_FLOAT: select_inc = inc_float;
            `EV_BP0: select_inc = inc_t'(breakpoint_status_pins[0]);
            `EV_BP1: select_inc = inc_t'(breakpoint_status_pins[1]);
            `EV_BP2: select_inc = inc_t'(breakpoint_status_pins[2]);
            `EV_BP3: select_inc = inc_t'(breakpoint_status_pins[3]);
            `EV_HW_IRQ: select_inc = inc_irq;
            `EV_DATA_ACC: select_inc = inc_acc;
            `EV_DATA_MISS: select_inc = inc_miss;
            `EV_BUS_OWN: begin
                select_inc = second ? inc_t'(req_rise) :
                    inc_t'(own_clock);
            end
            `EV_PACKED: begin
                select_inc = second ? inc_t'(packed_int_second) :
                    inc_t'(packed_int_first);
            end
            default: select_inc = '0;
        endcase
    endfunction : select_inc

    count_t next_count_0, next_count_1;

    always_comb begin
        // Counters wrap; overflow handling lives elsewhere
        next_count_0 = count_0 + count_t'(select_inc(evsel_0, 1'b0));
        next_count_1 = count_1 + count_t'(select_inc(evsel_1, 1'b1));
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count_0 <= '0;
            count_1 <= '0;
        end else begin
            count_0 <= next_count_0;
            count_1 <= next_count_1;
        end
    end
endmodule : perf_event_select_count

`default_nettype wire

// >>> tb/perf_event_monitor.sv
// Checker bound to the event select and count block.
// Assumes counts move on the edge that takes an event.
`timescale 1ns/10ps
`default_nettype none
`include "perf_event_consts.svh"

module perf_event_monitor (
    input wire logic mclk,
    input wire logic rst_b,
    input wire perf_types_pkg::evsel_t evsel_0,
    input wire perf_types_pkg::evsel_t evsel_1,
    input wire logic maskable_irq_taken,
    input wire logic nmi_taken,
    input wire logic [1:0] acc_valid,
    input wire logic [1:0] acc_tlb,
    input wire logic [1:0] acc_io,
    input wire logic packed_int_second,
    input wire logic [`BP_W-1:0] bp_code_first,
    input wire logic [`BP_W-1:0] bp_code_second,
    input wire logic [`BP_W-1:0] bp_data,
    input wire logic bp_enabled,
    input wire logic [`BP_W-1:0] breakpoint_status_pins,
    input wire perf_types_pkg::count_t count_0,
    input wire perf_types_pkg::count_t count_1
);
    import perf_types_pkg::*;
    logic [`BP_W-1:0] bp_want;
    always_comb begin
        bp_want = bp_code_first | bp_data
            | (bp_code_second & {`BP_W{bp_enabled}});
    end
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    property p_rsvd;
        evsel_0 == `EV_RSVD_A || evsel_0 == `EV_RSVD_B |=> $stable(count_0);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("count 0 moved");
    property p_range;
        evsel_1 < 6'h1F || evsel_1 > 6'h2B |=> $stable(count_1);
    endproperty
    a_range: assert property (p_range) else $error("count 1 moved");
    property p_irq;
        evsel_0 == `EV_HW_IRQ && (maskable_irq_taken ^ nmi_taken)
            |=> count_0 == $past(count_0) + 40'h1;
    endproperty
    a_irq: assert property (p_irq) else $error("irq count");
    property p_acc;
        evsel_1 == `EV_DATA_ACC && acc_valid == 2'h3 && (acc_tlb | acc_io) == 0
            |=> count_1 == $past(count_1) + 40'h2;
    endproperty
    a_acc: assert property (p_acc) else $error("access count");
    property p_acc_none;
        evsel_1 == `EV_DATA_ACC && (acc_valid & ~(acc_tlb | acc_io)) == 2'h0
            |=> $stable(count_1);
    endproperty
    a_acc_none: assert property (p_acc_none) else $error("access");
    property p_pack;
        evsel_1 == `EV_PACKED
            |=> count_1 == $past(count_1) + $past(packed_int_second);
    endproperty
    a_pack: assert property (p_pack) else $error("packed count");
    property p_pins;
        $past(rst_b) |-> breakpoint_status_pins == $past(bp_want);
    endproperty
    a_pins: assert property (p_pins) else $error("pins");
    property p_bp_cnt;
        evsel_0 == `EV_BP0 |=> count_0
            == $past(count_0) + ($past(breakpoint_status_pins) & 4'h1);
    endproperty
    a_bp_cnt: assert property (p_bp_cnt) else $error("bp count");
    c_own: cover property (evsel_0 == `EV_BUS_OWN ##1 $changed(count_0));
    c_miss: cover property (evsel_0 == `EV_DATA_MISS ##1 $changed(count_0));
    c_pins: cover property (breakpoint_status_pins != 4'h0);
endmodule : perf_event_monitor

bind perf_event_select_count perf_event_monitor perf_event_monitor_i (.*);

`default_nettype wire

// >>> tb/bus_agent.sv
// Bus-pin model: private request and grant, burst ready for fills.
// Assumes ask and fill pulses driven on rising edges of mclk.
`timescale 1ns/10ps
`default_nettype none

module bus_agent (
    input wire logic mclk,
    input wire logic ask,
    input wire logic fill,
    input wire logic [3:0] lat,
    output logic private_bus_request,
    output logic private_bus_grant,
    output logic burst_ready_b
);
    initial begin
        private_bus_request = 1'b0;
        private_bus_grant = 1'b0;
        burst_ready_b = 1'b1;
        forever begin
            @(posedge mclk);
            if (ask) begin
                // Zero latency raises grant with request, the awkward case
                private_bus_request <= 1'b1;
                repeat (lat) @(posedge mclk);
                private_bus_grant <= 1'b1;
                @(posedge mclk);
                {private_bus_request, private_bus_grant} <= 2'h0;
            end
            if (fill) begin
                repeat (4) begin
                    @(posedge mclk);
                    burst_ready_b <= 1'b0;
                    @(posedge mclk);
                    burst_ready_b <= 1'b1;
                end
            end
        end
    end
endmodule : bus_agent

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the event select and count block.
// Assumes the bus agent model; the checker binds itself.
`timescale 1ns/10ps
`default_nettype none
`include "perf_event_consts.svh"

module testbench;
    import perf_types_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    evsel_t evsel_0, evsel_1;
    logic ex_wr_first, ex_wr_second, ag_base_used_first, ag_index_used_first;
    logic ag_base_used_second, ag_index_used_second, float_op_event;
    logic float_exc_zero_div, float_exc_neg_sqrt, float_exc_special;
    logic float_exc_stack, int_mul_event, fpu_use_event, maskable_irq_taken;
    logic nmi_taken, packed_int_first, packed_int_second, ask, fill;
    logic bp_enabled, burst_ready_b, private_bus_request, private_bus_grant;
    logic [`REG_W-1:0] ex_dest_first, ex_dest_second, ag_base_first;
    logic [`REG_W-1:0] ag_index_first, ag_base_second, ag_index_second;
    logic [`FP_CNT_W-1:0] float_op_count;
    logic [`BP_W-1:0] bp_code_first, bp_code_second, bp_data;
    logic [`BP_W-1:0] breakpoint_status_pins;
    logic [1:0] acc_valid, acc_tlb, acc_io, acc_miss, acc_fill;
    line_t acc_line_0, acc_line_1;
    logic peer_hit_modified_b = 1'b1;
    logic snoop_hit_modified_b = 1'b1;
    logic [3:0] lat = 4'h3;
    count_t count_0, count_1, b0, b1;
    int failures = 0;
    int n_tests = 0;
    always #12.5 mclk = ~mclk;
    perf_event_select_count perf_event_select_count_i (.*);
    bus_agent bus_agent_i (.*);
    task automatic chk(input string what, input count_t got, count_t exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    task automatic clr;
        {ex_wr_first, ex_wr_second, ag_base_used_first, ag_index_used_first,
            ag_base_used_second, ag_index_used_second, float_op_event,
            float_exc_zero_div, float_exc_neg_sqrt, float_exc_special,
            float_exc_stack, int_mul_event, fpu_use_event, bp_enabled,
            maskable_irq_taken, nmi_taken, packed_int_first,
            packed_int_second, ask, fill} <= '0;
        {ex_dest_first, ex_dest_second, ag_base_first, ag_index_first,
            ag_base_second, ag_index_second, float_op_count, bp_code_first,
            bp_code_second, bp_data, acc_valid, acc_tlb, acc_io, acc_miss,
            acc_fill, acc_line_0, acc_line_1} <= '0;
    endtask : clr
    task automatic sel(input evsel_t a, input evsel_t b);
        @(posedge mclk);
        {evsel_0, evsel_1} <= {a, b};
        @(negedge mclk);
        {b0, b1} = {count_0, count_1};
    endtask : sel
    // A quiet clock between pulses keeps each driver to one write per edge
    task automatic nx;
        @(posedge mclk);
        clr();
        @(posedge mclk);
    endtask : nx
    task automatic fin;
        @(posedge mclk);
        clr();
        repeat (3) @(negedge mclk);
    endtask : fin
    task automatic t_stall;
        sel(`EV_INTERLOCK, `EV_PACKED);
        nx();
        {ex_wr_first, ag_base_used_first, ag_index_used_second} <= 3'h7;
        {ex_dest_first, ag_base_first, ag_index_second} <= {3{3'h3}};
        {packed_int_first, packed_int_second} <= 2'h3;
        nx();
        {ex_wr_second, ex_dest_second, ag_base_first} <= {1'b1, 3'h5, 3'h5};
        fin();
        chk("stall", count_0 - b0, 40'h2);
        chk("packed", count_1 - b1, 40'h1);
        sel(`EV_PACKED, `EV_INTERLOCK);
        nx();
        {packed_int_first, ex_wr_second, ag_base_used_first} <= 3'h7;
        {ex_dest_second, ag_base_first} <= {2{3'h5}};
        fin();
        chk("packed first", count_0 - b0, 40'h1);
        chk("stall second", count_1 - b1, 40'h1);
    endtask : t_stall
    task automatic t_float;
        sel(`EV_RSVD_A, `EV_FLOAT);
        for (int e = 0; e < 4; e++) begin
            nx();
            {float_op_event, float_op_count} <= 4'hF;
            {float_exc_zero_div, float_exc_neg_sqrt, float_exc_special,
                float_exc_stack} <= 4'h1 << e;
        end
        nx();
        {float_op_event, float_op_count} <= 4'hD;
        {int_mul_event, fpu_use_event} <= 2'h3;
        fin();
        chk("float", count_1 - b1, 40'h7);
        chk("reserved", count_0 - b0, 40'h0);
    endtask : t_float
    task automatic t_bp;
        for (int k = 0; k < 4; k++) begin
            sel(evsel_t'(`EV_BP0 + k), 6'h3F);
            nx();
            bp_code_second <= 4'hF;
            nx();
            bp_code_first[k] <= 1'b1;
            nx();
            {bp_enabled, bp_code_second[k]} <= 2'h3;
            nx();
            bp_data[k] <= 1'b1;
            fin();
            chk("bp", count_0 - b0, 40'h3);
            chk("range", count_1 - b1, 40'h0);
        end
    endtask : t_bp
    task automatic t_irq;
        sel(`EV_HW_IRQ, `EV_DATA_ACC);
        nx();
        {maskable_irq_taken, acc_valid} <= 3'h7;
        nx();
        {nmi_taken, acc_valid, acc_tlb, acc_miss} <= 7'h7E;
        nx();
        {acc_valid, acc_io} <= 4'hE;
        fin();
        chk("irq", count_0 - b0, 40'h2);
        chk("access", count_1 - b1, 40'h3);
    endtask : t_irq
    task automatic t_miss;
        sel(`EV_DATA_MISS, `EV_RSVD_B);
        nx();
        {acc_valid, acc_miss, acc_fill, fill} <= 7'h2B;
        acc_line_0 <= 27'h40;
        nx();
        {acc_valid, acc_miss, acc_io} <= 6'h3E;
        {acc_line_0, acc_line_1} <= {27'h40, 27'h80};
        nx();
        {acc_valid, acc_miss, acc_tlb} <= 6'h15;
        nx();
        repeat (4) @(posedge mclk);
        // Fourth beat still filters; the next clock counts again
        {acc_valid, acc_miss} <= 4'h5;
        acc_line_0 <= 27'h40;
        repeat (2) @(posedge mclk);
        {acc_valid, acc_miss} <= 4'hF;
        {acc_line_0, acc_line_1} <= {27'h40, 27'hC0};
        fin();
        chk("miss", count_0 - b0, 40'h4);
        chk("reserved", count_1 - b1, 40'h0);
    endtask : t_miss
    task automatic t_bus;
        int i;
        sel(`EV_BUS_OWN, `EV_BUS_OWN);
        for (int n = 0; n < 2; n++) begin
            nx();
            {ask, lat} <= {1'b1, n ? 4'h0 : 4'h3};
            // A hit one clock before the request starts the wait sooner
            if (n) begin
                peer_hit_modified_b <= 1'b0;
            end else begin
                snoop_hit_modified_b <= 1'b0;
            end
            @(posedge mclk);
            clr();
            {peer_hit_modified_b, snoop_hit_modified_b} <= 2'h3;
            for (i = 0; i < 20 && private_bus_grant !== 1'b1; i++)
                @(posedge mclk);
            if (i == 20) begin
                failures++;
                finish_test();
            end
        end
        fin();
        chk("latency", count_0 - b0, 40'h5);
        chk("transfers", count_1 - b1, 40'h2);
    endtask : t_bus
    initial begin
        {evsel_0, evsel_1} = {`EV_RSVD_A, `EV_RSVD_A};
        clr();
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        t_stall();
        t_float();
        t_bp();
        t_irq();
        t_miss();
        t_bus();
        finish_test();
    end
endmodule : testbench

`default_nettype wire
